// file: inc/ioc_cfg.svh
// register offsets, field positions, reset values and timing counts for the oscillator control block
`ifndef IOC_CFG_SVH
`define IOC_CFG_SVH
// wishbone register indices (printed offsets are not all multiples of four, so byte address is index times four)
`define IOC_IDX_HF_CTRL     8'hb2
`define IOC_IDX_MULT        8'hb9
`define IOC_IDX_LF_CTRL     8'h86
`define IOC_IDX_IRQ_STATUS  8'hc0
`define IOC_IDX_IRQ_MASK    8'hc1
`define IOC_IDX_CAPT_CTRL   8'hc2
`define IOC_IDX_T2_CAPTURE  8'hc3
`define IOC_IDX_T3_CAPTURE  8'hc4
`define IOC_ADDR_W          10
// hf control fields
`define IOC_HF_EN_BIT       7
`define IOC_HF_RDY_BIT      6
`define IOC_HF_SUSP_BIT     5
`define IOC_HF_CTRL_RESET   8'hc0
// multiplier stub constant read value
`define IOC_MULT_VALUE      8'he0
// lf control fields
`define IOC_LF_EN_BIT       7
`define IOC_LF_RDY_BIT      6
`define IOC_LF_TRIM_RESET   4'h8
// interrupt bit positions
`define IOC_IRQ_HF_RDY      0
`define IOC_IRQ_LF_RDY      1
`define IOC_IRQ_WAKE        2
`define IOC_IRQ_T2_CAPT     3
`define IOC_IRQ_T3_CAPT     4
`define IOC_IRQ_W           5
// timing: hf settle and lf settle times in microseconds, clock period in ns
`define IOC_CLK_PERIOD_NS   100
`define IOC_HF_SETTLE_US    2
`define IOC_LF_SETTLE_US    10
`define IOC_HF_SETTLE_CYC   ((`IOC_HF_SETTLE_US * 1000 + `IOC_CLK_PERIOD_NS - 1) / `IOC_CLK_PERIOD_NS)
`define IOC_LF_SETTLE_CYC   ((`IOC_LF_SETTLE_US * 1000 + `IOC_CLK_PERIOD_NS - 1) / `IOC_CLK_PERIOD_NS)
`endif

// file: inc/ioc_pkg.sv
// types shared by the oscillator control block
package ioc_pkg;
  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ioc_wb_req_t;
  // wake event group
  typedef struct packed {
    logic port0_match;
    logic port1_match;
    logic timer3_overflow;
    logic usb_resume;
  } ioc_wake_t;
  // hf oscillator state
  typedef enum logic [1:0] {
    IOC_HF_OFF,
    IOC_HF_SETTLE,
    IOC_HF_RUN,
    IOC_HF_SUSP
  } ioc_hf_state_t;
endpackage

// file: rtl/ioc_clk_div.sv
// glitch-free power-of-two clock divider producing an enable pulse and a divided level
`timescale 1ns/1ps
module ioc_clk_div
  import ioc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // source tick and ratio (00 /8, 01 /4, 10 /2, 11 /1)
  input  wire logic       tick_in,
  input  wire logic [1:0] sel_in,
  // divided outputs
  output logic            pulse_out,
  output logic            level_out
);
  logic [2:0] count;     // free running divide counter
  logic [1:0] sel_live;  // ratio in use, changed only at a period boundary
  logic [2:0] limit;     // terminal count for the live ratio
  logic       wrap;      // end of one divided period

  // terminal count from the live ratio
  always_comb begin
    case (sel_live)
      2'b00:   limit = 3'h7;
      2'b01:   limit = 3'h3;
      2'b10:   limit = 3'h1;
      default: limit = 3'h0;
    endcase
  end

  assign wrap = tick_in && (count >= limit);

  // counter and ratio switch only at wrap, so no runt period appears
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count    <= 3'h0;
      sel_live <= 2'h0;
    end else if (wrap) begin
      count    <= 3'h0;
      sel_live <= sel_in;
    end else if (tick_in) begin
      count <= count + 3'h1;
    end
  end

  // registered outputs: pulse on wrap, level toggles each divided period
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulse_out <= 1'b0;
      level_out <= 1'b0;
    end else begin
      pulse_out <= wrap;
      if (wrap) begin
        level_out <= ~level_out;
      end
    end
  end
endmodule

// file: rtl/ioc_osc_ctrl.sv
// internal oscillator control registers with wishbone slave, dividers and lf capture
// Summary of operation
// - hf enable bit 7 runs oscillator, resets 1
// - bit 6 read-only ready at programmed frequency
// - writing suspend bit halts oscillator until wake
// - hf control bits 4:2 read zero
// - fixed divide-by-4 before selectable divider
// - hf divider 00 /8 to 11 /1
// - multiplier register is read-only present stub
// - multiplier bits 7:5 always read one
// - multiplier bits 4:0 always read zero
// - lf oscillator with 1,2,4,8 divider
// - four-bit lf fine trim is writable
// - timer2 captures falling, timer3 rising lf edges
// - capture copies timer count into reload
// - lf divider 00 /8 to 11 /1
// - lf ready clears on reset or divider change
// - wake on port matches, timer3 overflow, resume
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "ioc_cfg.svh"
module ioc_osc_ctrl
  import ioc_pkg::*;
#(
  parameter int HF_SETTLE_CYC = `IOC_HF_SETTLE_CYC,
  parameter int LF_SETTLE_CYC = `IOC_LF_SETTLE_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [9:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // wake events from outside logic, same clock
  input  wire logic        port0_match_in,
  input  wire logic        port1_match_in,
  input  wire logic        timer3_overflow_in,
  input  wire logic        usb_resume_in,
  // running timer counts, same clock
  input  wire logic [15:0] timer2_count_in,
  input  wire logic [15:0] timer3_count_in,
  // oscillator ticks (one-cycle enables) from the analog cells, same clock
  input  wire logic        hf_tick_in,
  input  wire logic        lf_tick_in,
  // oscillator controls and clock enables
  output logic             hf_run_out,
  output logic             lf_run_out,
  output logic [3:0]       lf_fine_trim_out,
  output logic             system_clock_en_out,
  output logic             lf_clock_en_out,
  output logic             lf_level_out,
  // interrupt
  output logic             irq_out
);
  // registers
  logic                     hf_osc_enable;      // hf enable
  logic                     suspend;            // suspend in force
  logic [1:0]               hf_divider_select;  // hf post divider
  logic                     lf_osc_enable;      // lf enable
  logic                     lf_ready;           // lf settled
  logic [3:0]               lf_fine_trim;       // lf trim
  logic [1:0]               lf_divider_select;  // lf divider
  logic                     t2_capt_mode;       // timer2 lf capture
  logic                     t3_capt_mode;       // timer3 lf capture
  logic [15:0]              t2_reload;          // timer2 reload capture
  logic [15:0]              t3_reload;          // timer3 reload capture
  logic [`IOC_IRQ_W-1:0]    irq_status;         // sticky events
  logic [`IOC_IRQ_W-1:0]    irq_mask;           // event enables
  ioc_hf_state_t            hf_state;           // hf oscillator state
  logic [15:0]              hf_settle;          // hf settle counter
  logic [15:0]              lf_settle;          // lf settle counter
  logic [1:0]               pre_count;          // fixed divide by 4
  logic                     pre_tick;           // prescaler output
  logic                     lf_div_pulse;       // lf divided pulse
  logic                     lf_level;           // lf divided level
  logic                     lf_level_d;         // delayed level for edges
  logic                     hf_freq_ready;      // hf running
  logic                     wake;               // any wake event
  logic                     bus_req;            // new access
  logic                     wr;                 // write strobe
  logic [7:0]               idx;                // register index
  logic                     lane0;              // low byte enabled
  logic [`IOC_IRQ_W-1:0]    events;             // events this cycle
  logic                     t2_capt;            // timer2 capture
  logic                     t3_capt;            // timer3 capture
  logic                     lf_div_write;       // write that changes lf divider

  // bus decode: one access answered one cycle later
  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr      = bus_req && wb_we_in;
  assign idx     = wb_adr_in[9:2];
  assign lane0   = wb_sel_in[0];
  assign lf_div_write = wr && lane0 && (idx == `IOC_IDX_LF_CTRL) &&
                        (wb_dat_in[1:0] != lf_divider_select);

  // wake sources
  assign wake = port0_match_in || port1_match_in || timer3_overflow_in || usb_resume_in;

  // ready only while running at frequency
  assign hf_freq_ready = (hf_state == IOC_HF_RUN);
  assign hf_run_out    = (hf_state == IOC_HF_SETTLE) || (hf_state == IOC_HF_RUN);
  assign lf_run_out    = lf_osc_enable;
  assign lf_fine_trim_out = lf_fine_trim;
  assign lf_clock_en_out  = lf_div_pulse;
  assign lf_level_out     = lf_level;

  // edges of divided lf output for capture
  assign t2_capt = t2_capt_mode && lf_level_d && !lf_level;
  assign t3_capt = t3_capt_mode && !lf_level_d && lf_level;

  // hf state machine: enable, settle, suspend and wake
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hf_state  <= IOC_HF_SETTLE;
      hf_settle <= 16'h0000;
    end else begin
      case (hf_state)
        IOC_HF_OFF: begin
          if (hf_osc_enable) begin
            hf_state  <= IOC_HF_SETTLE;
            hf_settle <= 16'h0000;
          end
        end
        IOC_HF_SETTLE: begin
          if (!hf_osc_enable) begin
            hf_state <= IOC_HF_OFF;
          end else if (suspend) begin
            hf_state <= IOC_HF_SUSP;
          end else if (hf_settle >= 16'(HF_SETTLE_CYC - 1)) begin
            hf_state <= IOC_HF_RUN;
          end else begin
            hf_settle <= hf_settle + 16'h0001;
          end
        end
        IOC_HF_RUN: begin
          if (!hf_osc_enable) begin
            hf_state <= IOC_HF_OFF;
          end else if (suspend) begin
            hf_state <= IOC_HF_SUSP;
          end
        end
        IOC_HF_SUSP: begin
          if (!suspend) begin
            hf_state  <= hf_osc_enable ? IOC_HF_SETTLE : IOC_HF_OFF;
            hf_settle <= 16'h0000;
          end
        end
        default: hf_state <= IOC_HF_OFF;
      endcase
    end
  end

  // hf control register write; suspend clears on wake
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hf_osc_enable     <= 1'(`IOC_HF_CTRL_RESET >> `IOC_HF_EN_BIT);
      suspend           <= 1'b0;
      hf_divider_select <= 2'b00;
    end else begin
      if (wake) begin
        suspend <= 1'b0;
      end else if (wr && lane0 && idx == `IOC_IDX_HF_CTRL && wb_dat_in[`IOC_HF_SUSP_BIT]) begin
        suspend <= 1'b1;
      end
      if (wr && lane0 && idx == `IOC_IDX_HF_CTRL) begin
        hf_osc_enable     <= wb_dat_in[`IOC_HF_EN_BIT];
        hf_divider_select <= wb_dat_in[1:0];
      end
    end
  end

  // fixed divide by 4 on hf ticks, stopped when not running
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pre_count <= 2'h0;
      pre_tick  <= 1'b0;
    end else begin
      pre_tick <= 1'b0;
      if (hf_freq_ready && hf_tick_in) begin
        pre_count <= pre_count + 2'h1;
        pre_tick  <= (pre_count == 2'h3);
      end
    end
  end

  // hf post divider, ratio switched at period boundary
  ioc_clk_div u_hf_div (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .tick_in   (pre_tick),
    .sel_in    (hf_divider_select),
    .pulse_out (system_clock_en_out),
    .level_out ()
  );

  // lf divider on lf ticks
  ioc_clk_div u_lf_div (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .tick_in   (lf_tick_in && lf_osc_enable),
    .sel_in    (lf_divider_select),
    .pulse_out (lf_div_pulse),
    .level_out (lf_level)
  );

  // lf control register and ready flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lf_osc_enable     <= 1'b0;
      lf_fine_trim      <= `IOC_LF_TRIM_RESET;
      lf_divider_select <= 2'b00;
      lf_ready          <= 1'b0;
      lf_settle         <= 16'h0000;
    end else begin
      if (wr && lane0 && idx == `IOC_IDX_LF_CTRL) begin
        lf_osc_enable     <= wb_dat_in[`IOC_LF_EN_BIT];
        lf_fine_trim      <= wb_dat_in[5:2];
        lf_divider_select <= wb_dat_in[1:0];
      end
      if (lf_div_write) begin
        lf_ready  <= 1'b0;
        lf_settle <= 16'h0000;
      end else if (lf_osc_enable && !lf_ready) begin
        if (lf_settle >= 16'(LF_SETTLE_CYC - 1)) begin
          lf_ready <= 1'b1;
        end else begin
          lf_settle <= lf_settle + 16'h0001;
        end
      end
    end
  end

  // capture control and captured counts
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      t2_capt_mode <= 1'b0;
      t3_capt_mode <= 1'b0;
      t2_reload    <= 16'h0000;
      t3_reload    <= 16'h0000;
      lf_level_d   <= 1'b0;
    end else begin
      lf_level_d <= lf_level;
      if (wr && lane0 && idx == `IOC_IDX_CAPT_CTRL) begin
        t2_capt_mode <= wb_dat_in[0];
        t3_capt_mode <= wb_dat_in[1];
      end
      if (t2_capt) begin
        t2_reload <= timer2_count_in;
      end
      if (t3_capt) begin
        t3_reload <= timer3_count_in;
      end
    end
  end

  // events for interrupt status
  always_comb begin
    events = '0;
    events[`IOC_IRQ_HF_RDY]  = (hf_state == IOC_HF_SETTLE) && hf_osc_enable && !suspend &&
                               (hf_settle >= 16'(HF_SETTLE_CYC - 1));
    events[`IOC_IRQ_LF_RDY]  = lf_osc_enable && !lf_ready && !lf_div_write &&
                               (lf_settle >= 16'(LF_SETTLE_CYC - 1));
    events[`IOC_IRQ_WAKE]    = wake && suspend;
    events[`IOC_IRQ_T2_CAPT] = t2_capt;
    events[`IOC_IRQ_T3_CAPT] = t3_capt;
  end

  // sticky status, write one to clear, set wins; mask register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      if (wr && lane0 && idx == `IOC_IDX_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wb_dat_in[`IOC_IRQ_W-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      if (wr && lane0 && idx == `IOC_IDX_IRQ_MASK) begin
        irq_mask <= wb_dat_in[`IOC_IRQ_W-1:0];
      end
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  // read data and ack; unmapped reads return zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= 32'h0000_0000;
      if (bus_req && !wb_we_in) begin
        case (idx)
          `IOC_IDX_HF_CTRL:    wb_dat_out[7:0] <= {hf_osc_enable, hf_freq_ready, suspend, 3'b000, hf_divider_select};
          `IOC_IDX_MULT:       wb_dat_out[7:0] <= `IOC_MULT_VALUE;
          `IOC_IDX_LF_CTRL:    wb_dat_out[7:0] <= {lf_osc_enable, lf_ready, lf_fine_trim, lf_divider_select};
          `IOC_IDX_IRQ_STATUS: wb_dat_out[`IOC_IRQ_W-1:0] <= irq_status;
          `IOC_IDX_IRQ_MASK:   wb_dat_out[`IOC_IRQ_W-1:0] <= irq_mask;
          `IOC_IDX_CAPT_CTRL:  wb_dat_out[1:0] <= {t3_capt_mode, t2_capt_mode};
          `IOC_IDX_T2_CAPTURE: wb_dat_out[15:0] <= t2_reload;
          `IOC_IDX_T3_CAPTURE: wb_dat_out[15:0] <= t3_reload;
          default:             wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// file: verif/ioc_osc_ctrl_checker.sv
// concurrent port checks for the oscillator control block
`timescale 1ns/1ps
module ioc_osc_ctrl_checker
  import ioc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // wishbone slave side
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [9:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_out,
  input  wire logic        wb_ack_out,
  // oscillator side
  input  wire logic        hf_run_out,
  input  wire logic        system_clock_en_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // a request the slave takes on this edge
  sequence s_take; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
  // answered reads of the two fixed-layout registers
  sequence s_rd_hf; wb_ack_out && !wb_we_in && wb_adr_in == 10'h2c8; endsequence
  sequence s_rd_mult; wb_ack_out && !wb_we_in && wb_adr_in == 10'h2e4; endsequence
  property p_ack_next; s_take |=> wb_ack_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero between answers");
  property p_hf_rsvd; s_rd_hf |-> wb_dat_out[4:2] == 3'b000 && wb_dat_out[31:8] == 24'h00_0000; endproperty
  a_hf_rsvd: assert property (p_hf_rsvd) else $error("hf control unused bits not zero");
  property p_mult; s_rd_mult |-> wb_dat_out == 32'h0000_00e0; endproperty
  a_mult: assert property (p_mult) else $error("multiplier stub value wrong");
  property p_sys_gap; system_clock_en_out |=> !system_clock_en_out [*3]; endproperty
  a_sys_gap: assert property (p_sys_gap) else $error("system clock enable faster than prescaler");
  property p_rdy_off; s_rd_hf ##0 !hf_run_out |-> !wb_dat_out[6]; endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready read high while oscillator halted");
  property p_reset; $fell(rst_in) |-> !wb_ack_out && hf_run_out && !system_clock_en_out; endproperty
  a_reset: assert property (p_reset) else $error("outputs not at reset state");
endmodule
bind ioc_osc_ctrl ioc_osc_ctrl_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .hf_run_out(hf_run_out), .system_clock_en_out(system_clock_en_out));

// file: verif/testbench.sv
// self-checking bench for the oscillator control block
`timescale 1ns/1ps
module testbench
  import ioc_pkg::*;
;
  // stimulus and observed signals
  logic        clk_in = 0, rst_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
  logic        port0_match_in = 0, port1_match_in = 0, timer3_overflow_in = 0, usb_resume_in = 0;
  logic        hf_tick_in = 1, lf_tick_in = 1;
  logic [9:0]  wb_adr_in = 0;
  logic [3:0]  wb_sel_in = 4'h1;
  logic [31:0] wb_dat_in = 0, wb_dat_out, q;
  logic [15:0] timer2_count_in = 0, timer3_count_in = 16'h8000;
  logic        wb_ack_out, hf_run_out, lf_run_out, system_clock_en_out, lf_clock_en_out, lf_level_out, irq_out;
  logic [3:0]  lf_fine_trim_out;
  int          errors = 0, n_compared = 0, c;
  ioc_osc_ctrl #(.HF_SETTLE_CYC(8), .LF_SETTLE_CYC(8)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .port0_match_in(port0_match_in), .port1_match_in(port1_match_in), .timer3_overflow_in(timer3_overflow_in),
    .usb_resume_in(usb_resume_in), .timer2_count_in(timer2_count_in), .timer3_count_in(timer3_count_in),
    .hf_tick_in(hf_tick_in), .lf_tick_in(lf_tick_in), .hf_run_out(hf_run_out), .lf_run_out(lf_run_out),
    .lf_fine_trim_out(lf_fine_trim_out), .system_clock_en_out(system_clock_en_out),
    .lf_clock_en_out(lf_clock_en_out), .lf_level_out(lf_level_out), .irq_out(irq_out));
  // 10 MHz clock
  initial forever #50 clk_in = ~clk_in;
  // free-running timers
  always @(posedge clk_in) begin
    timer2_count_in <= timer2_count_in + 16'h0001;
    timer3_count_in <= timer3_count_in + 16'h0001;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic wishbone cycle, read data left in q
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    wb_cyc_in <= 1;
    wb_stb_in <= 1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      $display("mismatch wb_ack expected 1 seen 0");
      tally_and_finish();
    end
    q = wb_dat_out;
    wb_cyc_in <= 0;
    wb_stb_in <= 0;
  endtask
  task automatic rc(input string nm, input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
    wb(0, a, 8'h00);
    chk(nm, {24'h00_0000, e}, q & {24'hff_ffff, m});
  endtask
  // count enable pulses over 256 cycles once a ratio change has settled
  task automatic cnt(input bit lf);
    c = 0;
    repeat (40) @(posedge clk_in);
    repeat (256) begin
      @(posedge clk_in);
      c += lf ? int'(lf_clock_en_out) : int'(system_clock_en_out);
    end
  endtask
  task automatic t_regs();
    rc("hf_reset", 10'h2c8, 8'hc0, 8'hff);
    rc("mult_reset", 10'h2e4, 8'he0, 8'hff);
    rc("lf_reset", 10'h218, 8'h20, 8'hff);
    wb(1, 10'h2e4, 8'h1f);
    rc("mult_ro", 10'h2e4, 8'he0, 8'hff);
    wb(1, 10'h2c8, 8'h9f);
    rc("hf_rsvd", 10'h2c8, 8'h83, 8'hbf);
    rc("unmapped", 10'h3f0, 8'h00, 8'hff);
  endtask
  task automatic t_hf_div();
    for (int s = 0; s < 4; s++) begin
      wb(1, 10'h2c8, 8'h80 | 8'(s));
      cnt(0);
      chk("sys_pulses", 256 / (4 * (8 >> s)), c);
    end
  endtask
  task automatic t_hf_off();
    wb(1, 10'h2c8, 8'h00);
    cnt(0);
    chk("sys_off", 0, c);
    chk("hf_run_off", 0, hf_run_out);
    rc("hf_off_rdy", 10'h2c8, 8'h00, 8'hff);
    wb(1, 10'h2c8, 8'h80);
    repeat (12) @(posedge clk_in);
    rc("hf_on_rdy", 10'h2c8, 8'hc0, 8'hff);
  endtask
  // suspend, then each wake source; the last pass runs with the wake interrupt masked
  task automatic t_susp();
    wb(1, 10'h304, 8'h04);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) wb(1, 10'h304, 8'h00);
      wb(1, 10'h2c8, 8'ha0);
      @(posedge clk_in);
      chk("susp_halt", 0, hf_run_out);
      rc("susp_bit", 10'h2c8, 8'ha0, 8'hff);
      @(posedge clk_in);
      {port0_match_in, port1_match_in, timer3_overflow_in, usb_resume_in} <= 4'h8 >> (k % 4);
      @(posedge clk_in);
      {port0_match_in, port1_match_in, timer3_overflow_in, usb_resume_in} <= 4'h0;
      // suspend clears on the wake edge, the oscillator restarts one edge later
      repeat (2) @(posedge clk_in);
      chk("wake_run", 1, hf_run_out);
      chk("wake_irq", k < 4, irq_out);
      rc("wake_stat", 10'h300, 8'h04, 8'h04);
      wb(1, 10'h300, 8'h04);
      rc("stat_clr", 10'h300, 8'h00, 8'h04);
      chk("irq_clr", 0, irq_out);
    end
  endtask
  task automatic t_lf();
    wb(1, 10'h218, 8'h97);
    repeat (12) @(posedge clk_in);
    chk("lf_trim", 4'h5, lf_fine_trim_out);
    chk("lf_run", 1, lf_run_out);
    rc("lf_rdy", 10'h218, 8'hd7, 8'hff);
    wb(1, 10'h218, 8'h3b);
    rc("lf_keep", 10'h218, 8'h7b, 8'hff);
    for (int s = 0; s < 4; s++) begin
      wb(1, 10'h218, 8'h80 | 8'(s));
      rc("lf_clr", 10'h218, 8'h80 | 8'(s), 8'hff);
      cnt(1);
      chk("lf_pulses", 256 / (8 >> s), c);
    end
  endtask
  // capture on divided low-frequency edges
  task automatic t_cap();
    logic [15:0] e2, e3;
    wb(1, 10'h218, 8'h80);
    wb(1, 10'h308, 8'h03);
    @(negedge lf_level_out);
    #1 e2 = timer2_count_in;
    wb(0, 10'h30c, 8'h00);
    chk("t2_cap", {16'h0000, e2}, q);
    @(posedge lf_level_out);
    #1 e3 = timer3_count_in;
    wb(0, 10'h310, 8'h00);
    chk("t3_cap", {16'h0000, e3}, q);
    rc("cap_stat", 10'h300, 8'h18, 8'h18);
  endtask
  // reset in mid-run brings the hf, lf, status and mask fields back to their defaults
  task automatic t_rst();
    wb(1, 10'h2c8, 8'h23);
    wb(1, 10'h218, 8'hbf);
    wb(1, 10'h304, 8'h1f);
    @(posedge clk_in);
    rst_in <= 1;
    repeat (3) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    chk("rst_run", 1, hf_run_out);
    chk("rst_ack", 0, wb_ack_out);
    chk("rst_irq", 0, irq_out);
    rc("rst_hf", 10'h2c8, 8'h80, 8'hff);
    rc("rst_lf", 10'h218, 8'h20, 8'hff);
    rc("rst_stat", 10'h300, 8'h00, 8'h1e);
    rc("rst_mask", 10'h304, 8'h00, 8'h1f);
    repeat (12) @(posedge clk_in);
    rc("rst_hf_rdy", 10'h2c8, 8'hc0, 8'hff);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 0;
    repeat (12) @(posedge clk_in);
    t_regs();
    t_hf_div();
    t_hf_off();
    t_susp();
    t_lf();
    t_cap();
    t_rst();
    tally_and_finish();
  end
  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #2_000_000;
    errors++;
    tally_and_finish();
  end
endmodule
